/* File: src/tcp_regs.vh */
// constants for the timer compare, pulse and pwm block
// included by the design file; byte registers on a 32-bit wishbone bus
`ifndef TCP_REGS_VH
`define TCP_REGS_VH
`define TCP_OFS_CTL2     8'h00
`define TCP_OFS_CTL1     8'h04
`define TCP_OFS_STAT     8'h08
`define TCP_OFS_IC1H     8'h0C
`define TCP_OFS_IC1L     8'h10
`define TCP_OFS_OC1H     8'h14
`define TCP_OFS_OC1L     8'h18
`define TCP_OFS_CNTH     8'h1C
`define TCP_OFS_CNTL     8'h20
`define TCP_OFS_ACNTH    8'h24
`define TCP_OFS_ACNTL    8'h28
`define TCP_OFS_IC2H     8'h2C
`define TCP_OFS_IC2L     8'h30
`define TCP_OFS_OC2H     8'h34
`define TCP_OFS_OC2L     8'h38
`define TCP_C1_CAPTURE_IRQ_ENABLE      7
`define TCP_C1_COMPARE_IRQ_ENABLE      6
`define TCP_C1_TOIE      5
`define TCP_C1_FOLV2     4
`define TCP_C1_FOLV1     3
`define TCP_C1_OLVL2     2
`define TCP_C1_CAPTURE_EDGE_SELECT_ONE     1
`define TCP_C1_OLVL1     0
`define TCP_C2_OC1E      7
`define TCP_C2_OC2E      6
`define TCP_C2_OPM       5
`define TCP_C2_PWM       4
`define TCP_C2_CC_HI     3
`define TCP_C2_CC_LO     2
`define TCP_C2_IEDG2     1
`define TCP_C2_EXEDG     0
`define TCP_CC_DIV4      2'h0
`define TCP_CC_DIV2      2'h1
`define TCP_CC_DIV8      2'h2
`define TCP_CC_EXT       2'h3
`define TCP_ST_CAPTURE_FLAG_ONE      4
`define TCP_ST_OCF1      3
`define TCP_ST_TOF       2
`define TCP_ST_CAPTURE_FLAG_TWO      1
`define TCP_ST_OCF2      0
`define TCP_RST_CTL      8'h00
`define TCP_RST_OC       16'h8000
`define TCP_RST_CNT      16'hFFFC
`define TCP_OPM_CAP      16'hFFFD
`define TCP_CNT_MAX      16'hFFFF
`endif

/* File: src/tcp_timer.v */
// compare, one-pulse and pwm section of a 16-bit free running timer
// assumes a classic wishbone master on clk_in and a cpu interrupt mask level
`timescale 1ns/1ns
`default_nettype none
`include "tcp_regs.vh"

module tcp_timer (
  input  wire        clk_in,
  input  wire        rst_n_in,
  input  wire        wb_cyc_in,
  input  wire        wb_stb_in,
  input  wire        wb_we_in,
  input  wire [7:0]  wb_adr_in,
  input  wire [3:0]  wb_sel_in,
  input  wire [31:0] wb_dat_in,
  output reg  [31:0] wb_dat_out,
  output reg         wb_ack_out,
  input  wire        cpu_irq_mask_in,
  input  wire        capture_input_one_in,
  input  wire        capture_input_two_in,
  input  wire        ext_clock_in,
  output reg         compare_output_pin_one_out,
  output reg         compare_output_pin_two_out,
  output reg         compare_pin_enable_one_out,
  output reg         compare_pin_enable_two_out,
  output reg         timer_irq_out
);

  // compare target, one count later unless the timer runs at cpu/2
  function [15:0] tcp_target;
    input [15:0] value;
    input        div2;
    begin
      tcp_target = div2 ? value : value + 16'h0001;
    end
  endfunction

  // rising or falling edge of a synchronised level
  function tcp_edge;
    input now;
    input old;
    input rise;
    begin
      tcp_edge = rise ? (now & ~old) : (~now & old);
    end
  endfunction

  reg  [7:0]  ctl1_reg;
  reg  [7:0]  ctl2_reg;
  reg  [4:0]  stat_reg;
  reg  [4:0]  stat_next;
  reg  [4:0]  arm_reg;
  reg  [4:0]  flag_set;
  reg  [4:0]  flag_acc;
  reg  [15:0] oc1_reg;
  reg  [15:0] oc2_reg;
  reg  [15:0] ic1_reg;
  reg  [15:0] ic2_reg;
  reg  [15:0] cnt_reg;
  reg  [15:0] cnt_next;
  reg         oc1_hold_reg;
  reg         oc2_hold_reg;
  reg         ic1_hold_reg;
  reg         ic2_hold_reg;
  reg  [2:0]  presc_reg;
  reg         tick_d_reg;
  reg         tick;
  reg  [2:0]  cap1_sync_reg;
  reg  [2:0]  cap2_sync_reg;
  reg  [2:0]  ext_sync_reg;
  reg         pin1_next;
  reg         pin2_next;
  reg  [7:0]  rd_byte;

  wire        acc      = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  wire        rd       = acc & ~wb_we_in;
  wire        wr       = acc & wb_we_in & wb_sel_in[0];
  wire        rdwr     = rd | wr;
  wire [7:0]  wd       = wb_dat_in[7:0];
  wire [1:0]  cc       = ctl2_reg[`TCP_C2_CC_HI:`TCP_C2_CC_LO];
  wire        div2     = (cc == `TCP_CC_DIV2);
  wire        pwm_act  = ctl2_reg[`TCP_C2_PWM];
  wire        opm_act  = ctl2_reg[`TCP_C2_OPM] & ~pwm_act;
  wire        normal   = ~opm_act & ~pwm_act;
  wire        oc1e     = ctl2_reg[`TCP_C2_OC1E];
  wire        oc2e     = ctl2_reg[`TCP_C2_OC2E];
  wire        olvl1    = ctl1_reg[`TCP_C1_OLVL1];
  wire        olvl2    = ctl1_reg[`TCP_C1_OLVL2];
  wire        hit_oc1l = (wb_adr_in == `TCP_OFS_OC1L);
  wire        hit_oc2l = (wb_adr_in == `TCP_OFS_OC2L);
  wire        hit_cntl = (wb_adr_in == `TCP_OFS_CNTL);
  wire        hit_acnl = (wb_adr_in == `TCP_OFS_ACNTL);
  wire        hit_ic1h = (wb_adr_in == `TCP_OFS_IC1H);
  wire        hit_ic1l = (wb_adr_in == `TCP_OFS_IC1L);
  wire        hit_ic2h = (wb_adr_in == `TCP_OFS_IC2H);
  wire        hit_ic2l = (wb_adr_in == `TCP_OFS_IC2L);
  // compare on every timer tick unless an OCxH write holds it until OCxL, one cycle after the count settles
  wire        match1   = tick_d_reg & ~oc1_hold_reg &
                         (cnt_reg ==
                          tcp_target(oc1_reg, div2));
  wire        match2   = tick_d_reg & ~oc2_hold_reg &
                         (cnt_reg ==
                          tcp_target(oc2_reg, div2));
  wire        edge1    = tcp_edge(cap1_sync_reg[1], cap1_sync_reg[2],
                                  ctl1_reg[`TCP_C1_CAPTURE_EDGE_SELECT_ONE]);
  wire        edge2    = tcp_edge(cap2_sync_reg[1], cap2_sync_reg[2],
                                  ctl2_reg[`TCP_C2_IEDG2]);
  wire        ext_edge = tcp_edge(ext_sync_reg[1], ext_sync_reg[2],
                                  ctl2_reg[`TCP_C2_EXEDG]);
  wire        opm_trig = opm_act & edge1;
  wire        cap1_ok  = normal & edge1 & ~ic1_hold_reg;
  wire        cap2_ok  = edge2 & ~ic2_hold_reg;
  wire [4:0]  irq_en   = {ctl1_reg[`TCP_C1_CAPTURE_IRQ_ENABLE], ctl1_reg[`TCP_C1_COMPARE_IRQ_ENABLE],
                          ctl1_reg[`TCP_C1_TOIE], ctl1_reg[`TCP_C1_CAPTURE_IRQ_ENABLE],
                          ctl1_reg[`TCP_C1_COMPARE_IRQ_ENABLE]};

  // timer tick from the prescaler or the synchronised external clock
  always @* begin
    if (cc == `TCP_CC_DIV2) begin
      tick = presc_reg[0];
    end else if (cc == `TCP_CC_DIV4) begin
      tick = (presc_reg[1:0] == 2'h3);
    end else if (cc == `TCP_CC_DIV8) begin
      tick = (presc_reg == 3'h7);
    end else begin
      tick = ext_edge;
    end
  end

  // counter with its reload sources
  always @* begin
    cnt_next = cnt_reg;
    if (tick) begin
      cnt_next = cnt_reg + 16'h0001;
    end
    if (wr & (hit_cntl | hit_acnl)) begin
      cnt_next = `TCP_RST_CNT;
    end else if (opm_trig) begin
      cnt_next = `TCP_RST_CNT;
    end else if (pwm_act & match2) begin
      cnt_next = `TCP_RST_CNT;
    end
  end

  // flag set and two-step clear, a set wins over a clear
  always @* begin
    flag_set = 5'h00;
    flag_set[`TCP_ST_OCF1] = match1 & normal;
    flag_set[`TCP_ST_OCF2] = match2 &
                             ~pwm_act;
    flag_set[`TCP_ST_CAPTURE_FLAG_ONE] = cap1_ok | opm_trig |
                             (pwm_act & match2);
    flag_set[`TCP_ST_CAPTURE_FLAG_TWO] = cap2_ok;
    flag_set[`TCP_ST_TOF]  = tick & (cnt_reg == `TCP_CNT_MAX);
    flag_acc = 5'h00;
    flag_acc[`TCP_ST_OCF1] = rdwr & hit_oc1l;
    flag_acc[`TCP_ST_OCF2] = rdwr & hit_oc2l;
    flag_acc[`TCP_ST_CAPTURE_FLAG_ONE] = rdwr & hit_ic1l;
    flag_acc[`TCP_ST_CAPTURE_FLAG_TWO] = rdwr & hit_ic2l;
    flag_acc[`TCP_ST_TOF]  = rdwr & hit_cntl;
    stat_next = flag_set |
                (stat_reg & ~(arm_reg & flag_acc));
  end

  // compare pin levels; forcing only in plain compare mode
  always @* begin
    pin1_next = compare_output_pin_one_out;
    pin2_next = compare_output_pin_two_out;
    if (oc1e) begin
      if (normal) begin
        if (ctl1_reg[`TCP_C1_FOLV1] | match1) begin
          pin1_next = olvl1;
        end
      end else if (pwm_act) begin
        if (match2) begin
          pin1_next = olvl2;
        end else if (match1) begin
          pin1_next = olvl1;
        end
      end else begin
        if (opm_trig) begin
          pin1_next = olvl2;
        end else if (match1) begin
          pin1_next = olvl1;
        end
      end
    end
    if (oc2e & normal) begin
      if (ctl1_reg[`TCP_C1_FOLV2] | match2) begin
        pin2_next = olvl2;
      end
    end
  end

  // register read mux
  always @* begin
    rd_byte = 8'h00;
    if (wb_adr_in == `TCP_OFS_CTL2) begin
      rd_byte = ctl2_reg;
    end else if (wb_adr_in == `TCP_OFS_CTL1) begin
      rd_byte = ctl1_reg;
    end else if (wb_adr_in == `TCP_OFS_STAT) begin
      rd_byte = {stat_reg, 3'h0};
    end else if (hit_ic1h) begin
      rd_byte = ic1_reg[15:8];
    end else if (hit_ic1l) begin
      rd_byte = ic1_reg[7:0];
    end else if (wb_adr_in == `TCP_OFS_OC1H) begin
      rd_byte = oc1_reg[15:8];
    end else if (hit_oc1l) begin
      rd_byte = oc1_reg[7:0];
    end else if ((wb_adr_in == `TCP_OFS_CNTH) |
                 (wb_adr_in == `TCP_OFS_ACNTH)) begin
      rd_byte = cnt_reg[15:8];
    end else if (hit_cntl | hit_acnl) begin
      rd_byte = cnt_reg[7:0];
    end else if (hit_ic2h) begin
      rd_byte = ic2_reg[15:8];
    end else if (hit_ic2l) begin
      rd_byte = ic2_reg[7:0];
    end else if (wb_adr_in == `TCP_OFS_OC2H) begin
      rd_byte = oc2_reg[15:8];
    end else if (hit_oc2l) begin
      rd_byte = oc2_reg[7:0];
    end
  end

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctl1_reg      <= `TCP_RST_CTL;
      ctl2_reg      <= `TCP_RST_CTL;
      stat_reg      <= 5'h00;
      arm_reg       <= 5'h00;
      oc1_reg       <= `TCP_RST_OC;
      oc2_reg       <= `TCP_RST_OC;
      ic1_reg       <= 16'h0000;
      ic2_reg       <= 16'h0000;
      cnt_reg       <= `TCP_RST_CNT;
      oc1_hold_reg  <= 1'b0;
      oc2_hold_reg  <= 1'b0;
      ic1_hold_reg  <= 1'b0;
      ic2_hold_reg  <= 1'b0;
      presc_reg     <= 3'h0;
      tick_d_reg    <= 1'b0;
      cap1_sync_reg <= 3'h0;
      cap2_sync_reg <= 3'h0;
      ext_sync_reg  <= 3'h0;
      wb_ack_out    <= 1'b0;
      wb_dat_out    <= 32'h00000000;
      compare_output_pin_one_out <= 1'b0;
      compare_output_pin_two_out <= 1'b0;
      compare_pin_enable_one_out <= 1'b0;
      compare_pin_enable_two_out <= 1'b0;
      timer_irq_out <= 1'b0;
    end else begin
      presc_reg     <= presc_reg + 3'h1;
      tick_d_reg    <= tick;
      cap1_sync_reg <= {cap1_sync_reg[1:0], capture_input_one_in};
      cap2_sync_reg <= {cap2_sync_reg[1:0], capture_input_two_in};
      ext_sync_reg  <= {ext_sync_reg[1:0], ext_clock_in};
      cnt_reg       <= cnt_next;
      stat_reg      <= stat_next;
      if (rd & (wb_adr_in == `TCP_OFS_STAT)) begin
        arm_reg <= stat_reg;
      end else begin
        arm_reg <= arm_reg & ~flag_acc;
      end
      wb_ack_out <= acc;
      wb_dat_out <= {24'h000000, rd_byte};
      if (wr & (wb_adr_in == `TCP_OFS_CTL1)) begin
        ctl1_reg <= wd;
      end
      if (wr & (wb_adr_in == `TCP_OFS_CTL2)) begin
        ctl2_reg <= wd;
      end
      if (wr & (wb_adr_in == `TCP_OFS_OC1H)) begin
        oc1_reg[15:8] <= wd;
        oc1_hold_reg  <= 1'b1;
      end else if (wr & hit_oc1l) begin
        oc1_reg[7:0]  <= wd;
        oc1_hold_reg  <= 1'b0;
      end
      if (wr & (wb_adr_in == `TCP_OFS_OC2H)) begin
        oc2_reg[15:8] <= wd;
        oc2_hold_reg  <= 1'b1;
      end else if (wr & hit_oc2l) begin
        oc2_reg[7:0]  <= wd;
        oc2_hold_reg  <= 1'b0;
      end
      // reading a capture high byte holds that capture until its low byte, except that a one-pulse trigger still loads IC1
      if (rd & hit_ic1h) begin
        ic1_hold_reg <= 1'b1;
      end else if (rd & hit_ic1l) begin
        ic1_hold_reg <= 1'b0;
      end
      if (rd & hit_ic2h) begin
        ic2_hold_reg <= 1'b1;
      end else if (rd & hit_ic2l) begin
        ic2_hold_reg <= 1'b0;
      end
      if (opm_trig) begin
        ic1_reg <= `TCP_OPM_CAP;
      end else if (cap1_ok) begin
        ic1_reg <= cnt_reg;
      end
      if (cap2_ok) begin
        ic2_reg <= cnt_reg;
      end
      compare_output_pin_one_out <= pin1_next;
      compare_output_pin_two_out <= pin2_next;
      compare_pin_enable_one_out <= oc1e;
      compare_pin_enable_two_out <= oc2e;
      timer_irq_out <= ~cpu_irq_mask_in &
                       (|(stat_reg & irq_en));
    end
  end

endmodule
`default_nettype wire

/* File: tb/tcp_timer_checker.sv */
// concurrent checks on the ports of the compare, pulse and pwm timer
// bound to tcp_timer from the bench top; one clock, async low reset
`timescale 1ns/1ns
`default_nettype none
`include "tcp_regs.vh"
module tcp_timer_checker (
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [7:0]  wb_adr_in,
  input wire logic [3:0]  wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  input wire logic        cpu_irq_mask_in,
  input wire logic        capture_input_one_in,
  input wire logic        capture_input_two_in,
  input wire logic        ext_clock_in,
  input wire logic        compare_output_pin_one_out,
  input wire logic        compare_output_pin_two_out,
  input wire logic        compare_pin_enable_one_out,
  input wire logic        compare_pin_enable_two_out,
  input wire logic        timer_irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_req; wb_cyc_in && wb_stb_in && !wb_ack_out; endsequence
  sequence s_ack_pulse; wb_ack_out ##1 !wb_ack_out; endsequence
  property p_ack_once; s_req |=> s_ack_pulse; endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack not one pulse after request");
  property p_ack_cause; wb_ack_out |-> $past(wb_cyc_in && wb_stb_in);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_dat_hi; wb_ack_out |-> wb_dat_out[31:8] == 24'h000000;
  endproperty
  a_dat_hi: assert property (p_dat_hi)
    else $error("upper read data not zero");
  property p_irq_mask; $past(cpu_irq_mask_in) |-> !timer_irq_out;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("irq raised while masked");
  property p_pin1_hold;
    !compare_pin_enable_one_out && $past(!compare_pin_enable_one_out)
      |-> $stable(compare_output_pin_one_out);
  endproperty
  a_pin1_hold: assert property (p_pin1_hold)
    else $error("pin one moved while disabled");
  property p_pin2_hold;
    !compare_pin_enable_two_out && $past(!compare_pin_enable_two_out)
      |-> $stable(compare_output_pin_two_out);
  endproperty
  a_pin2_hold: assert property (p_pin2_hold)
    else $error("pin two moved while disabled");
  property p_en_write;
    $changed(compare_pin_enable_one_out) |-> $past(wb_ack_out
      && wb_we_in && wb_adr_in == `TCP_OFS_CTL2);
  endproperty
  a_en_write: assert property (p_en_write)
    else $error("pin enable changed without write");
  property p_rst_low;
    @(negedge clk_in) disable iff (1'b0) !rst_n_in |->
      !compare_output_pin_one_out && !compare_output_pin_two_out;
  endproperty
  a_rst_low: assert property (p_rst_low)
    else $error("pin latch not low in reset");
endmodule
`default_nettype wire

/* File: tb/tcp_pin_model.sv */
// pin side model: external timer clock and capture input edges
// driven just after clk_in edges; capture lines idle low
`timescale 1ns/1ns
`default_nettype none
module tcp_pin_model (
  input  wire logic clk_in,
  output var  logic ext_clock_out,
  output var  logic capture_one_out,
  output var  logic capture_two_out
);
  logic [1:0] div_reg = 2'h0;
  initial begin
    ext_clock_out = 1'b0;
    capture_one_out = 1'b0;
    capture_two_out = 1'b0;
  end
  // one eighth of clk_in, below the quarter limit
  always @(posedge clk_in) begin
    div_reg <= div_reg + 2'h1;
    if (div_reg == 2'h3) begin
      ext_clock_out <= ~ext_clock_out;
    end
  end
  // rising edge held four cycles
  task automatic pulse(input logic two);
    @(posedge clk_in);
    if (two) capture_two_out <= 1'b1;
    else capture_one_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    capture_one_out <= 1'b0;
    capture_two_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: tb/timer_compare_pulse_pwm_test.sv */
// self-checking bench: registers, compare timing, force, one-pulse, pwm
// pins come from tcp_pin_model; checker bound at the foot
`timescale 1ns/1ns
`default_nettype none
`include "tcp_regs.vh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  fails++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module timer_compare_pulse_pwm_test;
  logic        clk_in = 1'b0, rst_n_in = 1'b0, cyc = 1'b0, stb = 1'b0;
  logic        we = 1'b0, mask = 1'b0, lvl;
  logic [7:0]  adr = 8'h00, rq;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat_w = 32'h00000000;
  wire  [31:0] dat_r;
  wire         ack, pin1, pin2, pe1, pe2, irq, ext, cap1, cap2;
  int          fails = 0, total_checks = 0, c, c2;
  logic [7:0]  offs [4] = '{`TCP_OFS_OC1H, `TCP_OFS_OC1L,
                            `TCP_OFS_OC2H, `TCP_OFS_OC2L};
  logic [7:0]  v [4];
  logic [1:0]  ccs [4] = '{`TCP_CC_DIV2, `TCP_CC_DIV4, `TCP_CC_DIV8,
                           `TCP_CC_EXT};
  int          per [4] = '{2, 4, 8, 8};
  tcp_timer u_tcp_timer (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(sel), .wb_dat_in(dat_w), .wb_dat_out(dat_r),
    .wb_ack_out(ack), .cpu_irq_mask_in(mask),
    .capture_input_one_in(cap1), .capture_input_two_in(cap2),
    .ext_clock_in(ext), .compare_output_pin_one_out(pin1),
    .compare_output_pin_two_out(pin2), .compare_pin_enable_one_out(pe1),
    .compare_pin_enable_two_out(pe2), .timer_irq_out(irq));
  tcp_pin_model u_tcp_pin_model (.clk_in(clk_in), .ext_clock_out(ext),
    .capture_one_out(cap1), .capture_two_out(cap2));
  initial forever #20 clk_in = ~clk_in;
  task automatic wrap_up();
    if (fails == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    dat_w <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rq = dat_r[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      fails++;
      $display("[ERR] bus ack exp 1 got %0h", ack);
      wrap_up();
    end
  endtask
  task automatic wait_pin(input logic l, input int lim, output int k);
    k = 0;
    while (pin1 !== l && k < lim) begin
      @(negedge clk_in);
      k++;
    end
    if (k >= lim) begin
      fails++;
      $display("[ERR] pin one level exp %0h got %0h", l, pin1);
      wrap_up();
    end
  endtask
  // cycles from counter reload to the compare event
  function automatic int base_cycles(int m);
    return (6 + (m > 0 ? 1 : 0)) * per[m];
  endfunction
  initial begin
    void'($urandom(87501));
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, offs[i], 8'h00);
      `CHK("cmp reset", i[0] ? 8'h00 : 8'h80, rq)
      v[i] = 8'($urandom);
    end
    for (int i = 0; i < 4; i++) wb(1'b1, offs[i], v[i]);
    wb(1'b1, 8'h3C, 8'h5A);
    wb(1'b0, 8'h3C, 8'h00);
    `CHK("unmapped", 8'h00, rq)
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, offs[i], 8'h00);
      `CHK("cmp rw", v[i], rq)
    end
    for (int m = 0; m < 4; m++) begin
      lvl = ~pin1;
      wb(1'b1, `TCP_OFS_CTL1, {1'b0, 1'b1, 5'h00, lvl});
      wb(1'b1, `TCP_OFS_CTL2, {1'b1, 3'h0, ccs[m], 2'h1});
      wb(1'b1, `TCP_OFS_OC1H, 8'h00);
      wb(1'b0, `TCP_OFS_STAT, 8'h00);
      wb(1'b1, `TCP_OFS_OC1L, 8'h02);
      wb(1'b1, `TCP_OFS_CNTL, 8'h00);
      wait_pin(lvl, 200, c);
      `CHK("match time", 1'b1, c >= base_cycles(m) - per[m] + 2)
      `CHK("match late", 1'b1, c <= base_cycles(m) + 1)
      @(negedge clk_in);
      `CHK("irq", 1'b1, irq)
      @(posedge clk_in) mask <= 1'b1;
      repeat (2) @(negedge clk_in);
      `CHK("irq masked", 1'b0, irq)
      @(posedge clk_in) mask <= 1'b0;
      wb(1'b1, `TCP_OFS_OC1L, 8'h02);
      wb(1'b0, `TCP_OFS_STAT, 8'h00);
      `CHK("flag kept", 1'b1, rq[3+`TCP_ST_OCF1])
      wb(1'b1, `TCP_OFS_OC1L, 8'h02);
      wb(1'b0, `TCP_OFS_STAT, 8'h00);
      `CHK("flag clear", 1'b0, rq[3+`TCP_ST_OCF1])
    end
    wb(1'b1, `TCP_OFS_CTL1, 8'h09);
    wb(1'b1, `TCP_OFS_CTL2, 8'h84);
    wait_pin(1'b1, 20, c);
    wb(1'b0, `TCP_OFS_STAT, 8'h00);
    `CHK("force flag", 1'b0, rq[3+`TCP_ST_OCF1])
    wb(1'b1, `TCP_OFS_CTL2, 8'h04);
    wb(1'b1, `TCP_OFS_CTL1, 8'h08);
    repeat (4) @(negedge clk_in);
    `CHK("force off pin", 1'b1, pin1)
    wb(1'b1, `TCP_OFS_CTL2, 8'h84);
    wait_pin(1'b0, 20, c);
    wb(1'b1, `TCP_OFS_CTL1, 8'h06);
    wb(1'b1, `TCP_OFS_OC1H, 8'h00);
    wb(1'b1, `TCP_OFS_OC1L, 8'h04);
    wb(1'b1, `TCP_OFS_CTL2, 8'hA6);
    u_tcp_pin_model.pulse(1'b0);
    wait_pin(1'b1, 30, c);
    wait_pin(1'b0, 60, c);
    `CHK("pulse width", 1'b1, c >= 14 && c <= 20)
    wb(1'b0, `TCP_OFS_STAT, 8'h00);
    `CHK("opm cap flag", 1'b1, rq[3+`TCP_ST_CAPTURE_FLAG_ONE])
    `CHK("opm cmp flag", 1'b0, rq[3+`TCP_ST_OCF1])
    wb(1'b0, `TCP_OFS_IC1H, 8'h00);
    `CHK("opm cap hi", 8'hFF, rq)
    wb(1'b0, `TCP_OFS_IC1L, 8'h00);
    `CHK("opm cap lo", 8'hFD, rq)
    u_tcp_pin_model.pulse(1'b1);
    repeat (6) @(negedge clk_in);
    wb(1'b0, `TCP_OFS_STAT, 8'h00);
    `CHK("cap two", 1'b1, rq[3+`TCP_ST_CAPTURE_FLAG_TWO])
    wb(1'b0, `TCP_OFS_IC2L, 8'h00);
    wb(1'b1, `TCP_OFS_CTL1, 8'h09);
    wb(1'b1, `TCP_OFS_OC2H, 8'h00);
    wb(1'b0, `TCP_OFS_STAT, 8'h00);
    wb(1'b1, `TCP_OFS_OC2L, 8'h08);
    wb(1'b1, `TCP_OFS_CTL2, 8'hB4);
    wb(1'b1, `TCP_OFS_CNTL, 8'h00);
    wait_pin(1'b1, 80, c);
    wait_pin(1'b0, 80, c);
    wait_pin(1'b1, 80, c2);
    `CHK("pwm high", 1'b1, c >= 7 && c <= 9)
    `CHK("pwm low", 1'b1, c2 >= 15 && c2 <= 19)
    wb(1'b1, `TCP_OFS_CTL1, 8'h81);
    wb(1'b0, `TCP_OFS_STAT, 8'h00);
    `CHK("pwm cap flag", 1'b1, rq[3+`TCP_ST_CAPTURE_FLAG_ONE])
    `CHK("pwm cmp flags", 2'b00,
         {rq[3+`TCP_ST_OCF1], rq[3+`TCP_ST_OCF2]})
    `CHK("pwm irq", 1'b1, irq)
    wrap_up();
  end
endmodule
bind tcp_timer tcp_timer_checker u_tcp_timer_checker (.clk_in(clk_in),
  .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
  .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
  .cpu_irq_mask_in(cpu_irq_mask_in), .ext_clock_in(ext_clock_in),
  .capture_input_one_in(capture_input_one_in),
  .capture_input_two_in(capture_input_two_in),
  .compare_output_pin_one_out(compare_output_pin_one_out),
  .compare_output_pin_two_out(compare_output_pin_two_out),
  .compare_pin_enable_one_out(compare_pin_enable_one_out),
  .compare_pin_enable_two_out(compare_pin_enable_two_out),
  .timer_irq_out(timer_irq_out));
`default_nettype wire
